/* rtl/uafs_top.sv */
/*
 Enhanced line features of a serial port: character flow control,
 special character, half-duplex direction, infrared coding, sleep,
 loopback and register decode. Assumes the host port strobes, the
 receive/transmit core and the baud ticks are synchronous to clk_sys;
 serial and modem pins are asynchronous.
*/
// Overview of operation
// - compare received characters with pause/resume values
// - pause stops transmit after current character
// - pause match sets flag and interrupt
// - resume match restarts transmit, clears flag
// - reset clears the four flow characters
// - dual mode matches two consecutive characters
// - flow characters never reach receive buffer
// - send pause two characters after trigger
// - send resume at or below lower threshold
// - special character stored and flagged
// - compare only programmed word length bits
// - release direction after final stop bit
// - assert direction before first start bit
// - infrared 3/16 high pulse per zero
// - infrared decode with selectable polarity
// - sleep only when all conditions hold
// - sleep stops the oscillator
// - wake on start edge, write, modem change
// - resleep automatically, never with interrupt pending
// - loopback routes transmit to receive internally
// - decode by line control page and selector
`timescale 1ns/1ps
`default_nettype none
module uafs_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [2:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic thr_write,
	output logic [7:0] thr_data,
	output logic rhr_read,
	input wire logic [7:0] rhr_data,
	input wire logic [7:0] lsr_in,
	input wire logic core_int,
	input wire logic [7:0] rx_level,
	output logic [7:0] line_control,
	output logic [15:0] divisor,
	input wire uafs_pkg::uafs_char_s rx_in,
	input wire logic rx_in_valid,
	output logic rx_in_ready,
	output uafs_pkg::uafs_char_s rx_out,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [7:0] tx_flow_data,
	output logic tx_flow_valid,
	input wire logic tx_flow_ready,
	output logic tx_pause,
	input wire logic tx_busy,
	input wire logic tx_fifo_empty,
	input wire logic tx_shift_bit,
	input wire logic bit_start,
	input wire logic baud16_tick,
	input wire logic char_tick,
	output logic rx_serial,
	input wire logic rx_pin,
	output logic tx_pin,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic carrier_detect_n,
	input wire logic ring_indicate_n,
	output logic rts_n,
	output logic dtr_n,
	output logic half_duplex_direction_n,
	output logic int_out,
	output logic oscillator_output_en
);
	logic [7:0] lcr_q, mcr_q, ier_q, fcr_q, feature_control_q, efr_q, trg_q, spr_q, dll_q, dlm_q;
	logic [7:0] xon1_q, xon2_q, xoff1_q, xoff2_q, rdata_d, mask, hi_lvl, lo_lvl, hyst;
	logic [4:0] s1_q, s2_q, s3_q;
	logic [3:0] delta_q, ir_cnt_q;
	logic [4:0] str_q;
	logic [1:0] wait_q, rx_mode, tx_mode;
	logic enh, dlab, wr_ok, sleep_q, pause_q, spec_q, paused_q, held_v_q, sel_q, dir_q;
	logic first_off, first_on, pair_off, pair_on, ev_off, ev_on, push, push_held, spec_hit;
	logic loop, ir, msr_rd, isr_rd, modem_chg, rx_fall, wake, can_sleep, buf_ready, flow_done;
	uafs_pkg::uafs_char_s held_q, buf_in;
	uafs_pkg::uafs_flow_e fl_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign enh = lcr_q == uafs_pkg::ENH_KEY;
	assign dlab = lcr_q[uafs_pkg::LCR_DLAB] && !enh;
	assign loop = mcr_q[uafs_pkg::MCR_LOOP];
	assign ir = mcr_q[uafs_pkg::MCR_IR];
	assign wr_ok = bus_wr && !enh && !dlab;
	assign rhr_read = bus_rd && bus_addr == uafs_pkg::ADR_HOLD && !enh && !dlab;
	assign msr_rd = bus_rd && bus_addr == uafs_pkg::ADR_MSR && !enh;
	assign isr_rd = bus_rd && bus_addr == uafs_pkg::ADR_ISR && !enh;
	assign line_control = lcr_q;
	assign divisor = {dlm_q, dll_q};
	always_comb begin
		rdata_d = 8'h00;
		case (bus_addr)
			uafs_pkg::ADR_HOLD: rdata_d = enh ? trg_q : (dlab ? dll_q : rhr_data);
			uafs_pkg::ADR_IER: rdata_d = enh ? feature_control_q : (dlab ? dlm_q : ier_q);
			uafs_pkg::ADR_ISR: rdata_d = enh ? efr_q : {3'h0, pause_q | spec_q, 3'h0, !int_out};
			uafs_pkg::ADR_LCR: rdata_d = lcr_q;
			uafs_pkg::ADR_MCR: rdata_d = enh ? xon1_q : mcr_q;
			uafs_pkg::ADR_LSR: rdata_d = enh ? xon2_q : lsr_in;
			uafs_pkg::ADR_MSR: rdata_d = enh ? xoff1_q : {loop ? 4'h0 : ~s2_q[3:0], delta_q};
			default: rdata_d = enh ? xoff2_q : (feature_control_q[uafs_pkg::FEATURE_CONTROL_LVLSEL] ? rx_level : spr_q);
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			bus_rdata <= rdata_d;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			thr_write <= 1'b0;
			thr_data <= 8'h00;
		end else begin
			thr_write <= wr_ok && bus_addr == uafs_pkg::ADR_HOLD;
			if (wr_ok && bus_addr == uafs_pkg::ADR_HOLD) begin
				thr_data <= bus_wdata;
			end
		end
	end
	// a write to the selector-7 page while level select is set goes to a mode register this block does not hold
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{lcr_q, mcr_q, ier_q, fcr_q, feature_control_q, efr_q} <= {6{uafs_pkg::RST_BYTE}};
			{trg_q, spr_q, dll_q, dlm_q} <= {4{uafs_pkg::RST_BYTE}};
			{xon1_q, xon2_q, xoff1_q, xoff2_q} <= {4{uafs_pkg::RST_BYTE}};
		end else if (bus_wr) begin
			if (bus_addr == uafs_pkg::ADR_LCR) begin
				lcr_q <= bus_wdata;
			end else if (enh) begin
				case (bus_addr)
					uafs_pkg::ADR_TRG: trg_q <= bus_wdata;
					uafs_pkg::ADR_FEATURE_CONTROL: feature_control_q <= bus_wdata;
					uafs_pkg::ADR_EFR: efr_q <= bus_wdata;
					uafs_pkg::ADR_XON1: xon1_q <= bus_wdata;
					uafs_pkg::ADR_XON2: xon2_q <= bus_wdata;
					uafs_pkg::ADR_XOFF1: xoff1_q <= bus_wdata;
					default: xoff2_q <= bus_wdata;
				endcase
			end else begin
				case (bus_addr)
					uafs_pkg::ADR_HOLD: if (dlab) dll_q <= bus_wdata;
					uafs_pkg::ADR_IER: if (dlab) dlm_q <= bus_wdata; else ier_q <= bus_wdata;
					uafs_pkg::ADR_ISR: fcr_q <= bus_wdata;
					uafs_pkg::ADR_MCR: mcr_q <= bus_wdata;
					uafs_pkg::ADR_SPR: if (!feature_control_q[uafs_pkg::FEATURE_CONTROL_LVLSEL]) spr_q <= bus_wdata;
					default: ;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// receive character matching
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
		hit = ((a ^ b) & m) == 8'h00;
	endfunction
	assign mask = 8'(8'hFF >> (2'h3 - lcr_q[1:0]));
	assign rx_mode = efr_q[1:0];
	assign tx_mode = efr_q[3:2];
	assign first_off = hit(rx_in.data, rx_mode == uafs_pkg::MODE_SET2 ? xoff2_q : xoff1_q, mask);
	assign first_on = hit(rx_in.data, rx_mode == uafs_pkg::MODE_SET2 ? xon2_q : xon1_q, mask);
	assign pair_off = hit(held_q.data, xoff1_q, mask) && hit(rx_in.data, xoff2_q, mask);
	assign pair_on = hit(held_q.data, xon1_q, mask) && hit(rx_in.data, xon2_q, mask);
	// a held first character is flushed before the next one is looked at, so the input waits a cycle
	always_comb begin
		push = 1'b0;
		push_held = 1'b0;
		ev_off = 1'b0;
		ev_on = 1'b0;
		rx_in_ready = buf_ready;
		if (rx_in_valid && buf_ready) begin
			if (held_v_q) begin
				if (rx_mode == uafs_pkg::MODE_DUAL && (pair_off || pair_on)) begin
					ev_off = pair_off;
					ev_on = pair_on && !pair_off;
				end else begin
					push = 1'b1;
					push_held = 1'b1;
					rx_in_ready = 1'b0;
				end
			end else if (rx_mode == uafs_pkg::MODE_OFF) begin
				push = 1'b1;
			end else if (rx_mode != uafs_pkg::MODE_DUAL) begin
				ev_off = first_off;
				ev_on = first_on && !first_off;
				push = !first_off && !first_on;
			end else begin
				push = !hit(rx_in.data, xoff1_q, mask) && !hit(rx_in.data, xon1_q, mask);
			end
		end
	end
	assign buf_in = push_held ? held_q : rx_in;
	assign spec_hit = push && !push_held && efr_q[uafs_pkg::EFR_SPECIAL] && hit(rx_in.data, xoff2_q, mask);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			held_v_q <= 1'b0;
			held_q <= '0;
		end else if (rx_in_valid && buf_ready) begin
			held_v_q <= !held_v_q && rx_mode == uafs_pkg::MODE_DUAL && !push;
			if (!held_v_q) begin
				held_q <= rx_in;
			end
		end
	end
	uafs_buf #(.W($bits(uafs_pkg::uafs_char_s)), .DEPTH(2)) uafs_buf_inst (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_data(buf_in),
		.in_valid(push),
		.in_ready(buf_ready),
		.out_data(rx_out),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready)
	);
	// set wins over clear on every flag
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			paused_q <= 1'b0;
			pause_q <= 1'b0;
			spec_q <= 1'b0;
		end else begin
			if (ev_off) paused_q <= 1'b1;
			else if (ev_on) paused_q <= 1'b0;
			if (ev_off && ier_q[uafs_pkg::IER_PAUSE]) pause_q <= 1'b1;
			else if (ev_on) pause_q <= 1'b0;
			if (spec_hit) spec_q <= 1'b1;
			else if (isr_rd || ev_on) spec_q <= 1'b0;
		end
	end
	// core finishes the character in its shifter before it honours this
	assign tx_pause = paused_q;
	assign int_out = core_int || pause_q || spec_q;
	// ----------------------------------------------------------------
	// automatic pause/resume transmission
	// ----------------------------------------------------------------
	assign hyst = uafs_pkg::HYST_TAB[feature_control_q[1:0]];
	assign hi_lvl = feature_control_q[5:4] == uafs_pkg::TBL_PROG ? trg_q : uafs_pkg::TRIG_TAB[feature_control_q[5:4]][int'(fcr_q[7:6]) + 1];
	assign lo_lvl = feature_control_q[5:4] == uafs_pkg::TBL_PROG ? (trg_q > hyst ? 8'(trg_q - hyst) : 8'h00)
		: uafs_pkg::TRIG_TAB[feature_control_q[5:4]][fcr_q[7:6]];
	assign tx_flow_valid = fl_q == uafs_pkg::FL_SEND_OFF || fl_q == uafs_pkg::FL_SEND_ON;
	assign tx_flow_data = fl_q == uafs_pkg::FL_SEND_OFF ? (sel_q ? xoff2_q : xoff1_q) : (sel_q ? xon2_q : xon1_q);
	assign flow_done = tx_flow_ready && (sel_q || tx_mode != uafs_pkg::MODE_DUAL);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fl_q <= uafs_pkg::FL_RUN;
			wait_q <= 2'h0;
			sel_q <= 1'b0;
		end else begin
			unique case (fl_q)
				uafs_pkg::FL_RUN: begin
					wait_q <= 2'h0;
					if (tx_mode != uafs_pkg::MODE_OFF && rx_level >= hi_lvl) fl_q <= uafs_pkg::FL_WAIT;
				end
				uafs_pkg::FL_WAIT: begin
					sel_q <= tx_mode == uafs_pkg::MODE_SET2;
					if (char_tick) wait_q <= 2'(wait_q + 1'b1);
					if (char_tick && wait_q == 2'(uafs_pkg::PAUSE_DELAY_CHARS - 1'b1)) fl_q <= uafs_pkg::FL_SEND_OFF;
				end
				uafs_pkg::FL_SEND_OFF: begin
					if (tx_flow_ready) sel_q <= 1'b1;
					if (flow_done) fl_q <= uafs_pkg::FL_HALTED;
				end
				uafs_pkg::FL_HALTED: begin
					sel_q <= tx_mode == uafs_pkg::MODE_SET2;
					if (tx_mode == uafs_pkg::MODE_OFF) fl_q <= uafs_pkg::FL_RUN;
					else if (rx_level <= lo_lvl) fl_q <= uafs_pkg::FL_SEND_ON;
				end
				uafs_pkg::FL_SEND_ON: begin
					if (tx_flow_ready) sel_q <= 1'b1;
					if (flow_done) fl_q <= uafs_pkg::FL_RUN;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// pin synchronisers and modem change
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 5'h1F;
			s2_q <= 5'h1F;
			s3_q <= 5'h1F;
		end else begin
			s1_q <= {rx_pin, cts_n, dsr_n, carrier_detect_n, ring_indicate_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign modem_chg = !loop && s3_q[3:0] != s2_q[3:0];
	assign rx_fall = s3_q[4] && !s2_q[4];
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			delta_q <= 4'h0;
		end else if (modem_chg) begin
			delta_q <= delta_q | (s3_q[3:0] ^ s2_q[3:0]);
		end else if (msr_rd) begin
			delta_q <= 4'h0;
		end
	end
	// ----------------------------------------------------------------
	// sleep
	// ----------------------------------------------------------------
	assign can_sleep = !int_out && ier_q[uafs_pkg::IER_SLEEP] && delta_q == 4'h0 && s2_q[4];
	assign wake = rx_fall || thr_write || modem_chg || int_out;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sleep_q <= 1'b0;
		end else if (wake || !ier_q[uafs_pkg::IER_SLEEP]) begin
			sleep_q <= 1'b0;
		end else if (can_sleep) begin
			sleep_q <= 1'b1;
		end
	end
	// the oscillator pad cell stops when this drops
	assign oscillator_output_en = !sleep_q;
	// ----------------------------------------------------------------
	// infrared, loopback, direction and line outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ir_cnt_q <= 4'hF;
			str_q <= 5'h00;
		end else begin
			if (bit_start) ir_cnt_q <= 4'h0;
			else if (baud16_tick && ir_cnt_q != 4'hF) ir_cnt_q <= 4'(ir_cnt_q + 1'b1);
			// a pulse on the line stretches to a whole zero bit
			if ((s2_q[4] ^ feature_control_q[uafs_pkg::FEATURE_CONTROL_IRINV]) && !(s3_q[4] ^ feature_control_q[uafs_pkg::FEATURE_CONTROL_IRINV])) begin
				str_q <= uafs_pkg::IR_BIT_TICKS;
			end else if (baud16_tick && str_q != 5'h00) begin
				str_q <= 5'(str_q - 1'b1);
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_pin <= 1'b1;
			rx_serial <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			dir_q <= 1'b0;
		end else begin
			if (loop) tx_pin <= 1'b1;
			else if (ir) tx_pin <= !tx_shift_bit && ir_cnt_q < uafs_pkg::IR_PULSE_TICKS;
			else tx_pin <= tx_shift_bit;
			if (loop) rx_serial <= tx_shift_bit;
			else if (ir) rx_serial <= str_q == 5'h00;
			else rx_serial <= s2_q[4];
			rts_n <= loop || !mcr_q[uafs_pkg::MCR_RTS];
			dtr_n <= loop || !mcr_q[uafs_pkg::MCR_DTR];
			dir_q <= tx_busy || !tx_fifo_empty || thr_write;
		end
	end
	assign half_duplex_direction_n = !(mcr_q[uafs_pkg::MCR_DIR] && dir_q);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_pause_halts_tx: assert property (ev_off |=> tx_pause) else $error("pause match did not halt tx");
	a_pause_flag_int: assert property (ev_off && ier_q[uafs_pkg::IER_PAUSE] |=> pause_q && int_out)
		else $error("pause flag or interrupt missing");
	a_resume_clears: assert property (ev_on && !ev_off |=> !tx_pause && !pause_q) else $error("resume did not clear");
	a_flow_not_stored: assert property (ev_off || ev_on |-> !push) else $error("flow char stored");
	a_pause_delay: assert property (fl_q == uafs_pkg::FL_RUN ##1 fl_q == uafs_pkg::FL_WAIT
		|-> !tx_flow_valid [*2]) else $error("pause char sent early");
	a_sleep_entry: assert property (!sleep_q && (int_out || !ier_q[uafs_pkg::IER_SLEEP])
		|| !sleep_q && (delta_q != 4'h0 || !s2_q[4]) |=> !sleep_q) else $error("sleep entered illegally");
	a_wake_write: assert property (sleep_q && thr_write |=> !sleep_q && oscillator_output_en) else $error("no wake");
	a_ir_idle_low: assert property (ir && !loop && tx_shift_bit |=> !tx_pin) else $error("ir tx not idle low");
	a_loop_mark: assert property (loop |=> tx_pin && rts_n && dtr_n) else $error("loopback pins wrong");
	a_dir_release: assert property (mcr_q[uafs_pkg::MCR_DIR] && !tx_busy && tx_fifo_empty && !thr_write
		|=> half_duplex_direction_n) else $error("direction not released");
endmodule
`default_nettype wire

/* rtl/uafs_pkg.sv */
/*
 Shared constants and types for the serial line feature block: register
 offsets, bit positions, trigger tables and the receive character carrier.
 Assumes a byte-wide register port with three address lines.
*/
package uafs_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] ADR_HOLD = 3'h0;
	localparam logic [2:0] ADR_IER = 3'h1;
	localparam logic [2:0] ADR_ISR = 3'h2;
	localparam logic [2:0] ADR_LCR = 3'h3;
	localparam logic [2:0] ADR_MCR = 3'h4;
	localparam logic [2:0] ADR_LSR = 3'h5;
	localparam logic [2:0] ADR_MSR = 3'h6;
	localparam logic [2:0] ADR_SPR = 3'h7;
	localparam logic [2:0] ADR_DIV_LO = 3'h0;
	localparam logic [2:0] ADR_DIV_HI = 3'h1;
	localparam logic [2:0] ADR_TRG = 3'h0;
	localparam logic [2:0] ADR_FEATURE_CONTROL = 3'h1;
	localparam logic [2:0] ADR_EFR = 3'h2;
	localparam logic [2:0] ADR_XON1 = 3'h4;
	localparam logic [2:0] ADR_XON2 = 3'h5;
	localparam logic [2:0] ADR_XOFF1 = 3'h6;
	localparam logic [2:0] ADR_XOFF2 = 3'h7;
	localparam logic [7:0] ENH_KEY = 8'hBF;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ----------------------------------------------------------------
	// bit positions
	// ----------------------------------------------------------------
	localparam int LCR_DLAB = 7;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_DIR = 2;
	localparam int MCR_LOOP = 4;
	localparam int MCR_IR = 6;
	localparam int IER_SLEEP = 4;
	localparam int IER_PAUSE = 5;
	localparam int ISR_NOINT = 0;
	localparam int ISR_FLOW = 4;
	localparam int FEATURE_CONTROL_IRINV = 2;
	localparam int FEATURE_CONTROL_LVLSEL = 6;
	localparam int EFR_SPECIAL = 5;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SET2 = 2'h1;
	localparam logic [1:0] MODE_DUAL = 2'h3;
	localparam logic [1:0] TBL_PROG = 2'h3;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [4:0] IR_BIT_TICKS = 5'h10;
	localparam logic [1:0] PAUSE_DELAY_CHARS = 2'h2;
	// ----------------------------------------------------------------
	// trigger tables: entry 0 is the resume level of the first trigger
	// ----------------------------------------------------------------
	localparam logic [7:0] TRIG_TAB [3][5] = '{
		'{8'h00, 8'h01, 8'h04, 8'h08, 8'h0E},
		'{8'h00, 8'h08, 8'h10, 8'h18, 8'h1C},
		'{8'h00, 8'h08, 8'h10, 8'h38, 8'h3C}};
	localparam logic [7:0] HYST_TAB [4] = '{8'h00, 8'h04, 8'h06, 8'h08};
	typedef struct packed {
		logic [2:0] err;
		logic [7:0] data;
	} uafs_char_s;
	typedef enum logic [2:0] {FL_RUN, FL_WAIT, FL_SEND_OFF, FL_HALTED, FL_SEND_ON} uafs_flow_e;
endpackage

/* rtl/uafs_buf.sv */
/*
 Small FIFO with valid/ready on both sides, flip-flop storage.
 Assumes one clock; both sides are synchronous logic.
*/
`timescale 1ns/1ps
`default_nettype none
module uafs_buf #(
	parameter int W = 11,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	generate
		if (DEPTH < 2) begin : g_chk
			$error("uafs_buf needs at least two entries");
		end
	endgenerate
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic push, pop;
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : AW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : AW'(rp_q + 1'b1);
			end
			cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
		end
	end
endmodule
`default_nettype wire

/* verif/uafs_far_model.sv */
/*
 Far side of the block: receive fifo sink and transmit core flow-char taker,
 plus the idle receive pin. Assumes clk_sys and rst_n of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module uafs_far_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic fast,
	input wire logic [7:0] tx_flow_data,
	input wire logic tx_flow_valid,
	output logic tx_flow_ready,
	input wire uafs_pkg::uafs_char_s rx_out,
	input wire logic rx_out_valid,
	output logic rx_out_ready,
	output logic rx_pin,
	output logic [7:0] flow_last,
	output logic [7:0] rx_last,
	output logic [7:0] flow_cnt,
	output logic [7:0] rx_cnt
);
	logic ph_q;
	// line kept at mark so sleep and loopback exits stay clean
	assign rx_pin = 1'b1;
	// slow mode answers every other cycle
	assign tx_flow_ready = fast | ph_q;
	assign rx_out_ready = (fast | ph_q) & ~hold;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 1'b0;
			flow_last <= 8'h00;
			rx_last <= 8'h00;
			flow_cnt <= 8'h00;
			rx_cnt <= 8'h00;
		end else begin
			ph_q <= ~ph_q;
			if (tx_flow_valid && tx_flow_ready) begin
				flow_last <= tx_flow_data;
				flow_cnt <= flow_cnt + 8'h01;
			end
			if (rx_out_valid && rx_out_ready) begin
				rx_last <= rx_out.data;
				rx_cnt <= rx_cnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/uafs_tb_top.sv */
/*
 Self-checking bench: host port, receive chars, core ticks and pins.
 Assumes the far side model answers the core handshakes.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin bad_count++; \
	$display("wrong value at %0t, bench line %0d", $time, `__LINE__); end end
module uafs_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0, rx_in_valid = 1'b0;
	logic core_int = 1'b0, tx_busy = 1'b0, tx_fifo_empty = 1'b1, tx_shift_bit = 1'b1, bit_start = 1'b0;
	logic baud16_tick = 1'b0, char_tick = 1'b0, cts_n = 1'b1, dsr_n = 1'b1, carrier_detect_n = 1'b1;
	logic ring_indicate_n = 1'b1, hold = 1'b0, fast = 1'b1;
	logic [2:0] bus_addr = 3'h0;
	logic [7:0] bus_wdata = 8'h00, rhr_data = 8'h00, lsr_in = 8'h00, rx_level = 8'h00, d, n;
	logic [7:0] bus_rdata, thr_data, line_control, tx_flow_data, flow_last, rx_last, flow_cnt, rx_cnt;
	logic [15:0] divisor;
	logic [31:0] seed = 32'h09A09448;
	uafs_pkg::uafs_char_s rx_in = '0, rx_out;
	logic thr_write, rhr_read, rx_in_ready, rx_out_valid, rx_out_ready, tx_flow_valid, tx_flow_ready;
	logic tx_pause, rx_serial, rx_pin, tx_pin, rts_n, dtr_n, half_duplex_direction_n, int_out;
	logic oscillator_output_en;
	int bad_count = 0, cmp_count = 0, rhr_cnt = 0;
	uafs_top uafs_top_inst (.*);
	uafs_far_model uafs_far_model_inst (.*);
	always #5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) baud16_tick <= ~baud16_tick;
	always @(posedge clk_sys) if (rhr_read) rhr_cnt <= rhr_cnt + 1;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clk_sys);
		{bus_addr, bus_wdata, bus_wr} = {a, v, 1'b1};
		@(negedge clk_sys);
		bus_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(negedge clk_sys);
		{bus_addr, bus_rd} = {a, 1'b1};
		@(negedge clk_sys);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	task automatic put(input logic [7:0] c);
		@(negedge clk_sys);
		{rx_in.data, rx_in_valid} = {c, 1'b1};
		#1;
		for (int i = 0; i < 40 && !rx_in_ready; i++) begin
			@(negedge clk_sys);
			#1;
		end
		@(negedge clk_sys);
		rx_in_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic tick;
		@(negedge clk_sys);
		char_tick = 1'b1;
		@(negedge clk_sys);
		char_tick = 1'b0;
	endtask
	task automatic wait_osc(input logic v);
		for (int i = 0; i < 60 && oscillator_output_en !== v; i++) @(negedge clk_sys);
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#400000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		rst_n = 1'b1;
		wr(3'h3, 8'hBF);
		for (int a = 4; a < 8; a++) begin
			rd(a[2:0]);
			`CHK(d, 8'h00)
		end
		wr(3'h6, 8'h13);
		wr(3'h4, 8'h11);
		wr(3'h7, 8'h1A);
		wr(3'h5, 8'h22);
		rd(3'h6);
		`CHK(d, 8'h13)
		wr(3'h1, 8'h10);
		wr(3'h2, 8'h0A);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'hA5);
		wr(3'h1, 8'h5A);
		`CHK(divisor, 16'h5AA5)
		wr(3'h3, 8'h03);
		`CHK(line_control, 8'h03)
		wr(3'h1, 8'h20);
		wr(3'h2, 8'h41);
		wr(3'h7, seed[7:0]);
		rd(3'h7);
		`CHK(d, seed[7:0])
		rhr_data = 8'hC5;
		rd(3'h0);
		`CHK(d, 8'hC5)
		`CHK(rhr_cnt, 1)
		wr(3'h0, 8'h3C);
		`CHK(thr_data, 8'h3C)
		`CHK(thr_write, 1'b1)
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			put(seed[7:0] | 8'h80);
			`CHK(rx_last, seed[7:0] | 8'h80)
		end
		n = rx_cnt;
		put(8'h13);
		`CHK(tx_pause, 1'b1)
		`CHK(int_out, 1'b1)
		`CHK(rx_cnt, n)
		rd(3'h2);
		`CHK(d[4], 1'b1)
		put(8'h11);
		`CHK(tx_pause, 1'b0)
		`CHK(int_out, 1'b0)
		wr(3'h3, 8'h00);
		put({seed[7:5], 5'h13});
		`CHK(tx_pause, 1'b1)
		put({seed[10:8], 5'h11});
		`CHK(tx_pause, 1'b0)
		n = rx_cnt;
		hold = 1'b1;
		put(8'hA0);
		put(8'hA1);
		`CHK(rx_in_ready, 1'b0)
		hold = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHK(rx_cnt, n + 8'h02)
		wr(3'h3, 8'hBF);
		wr(3'h2, 8'h2A);
		wr(3'h3, 8'h03);
		put(8'h1A);
		`CHK(rx_last, 8'h1A)
		rd(3'h2);
		`CHK(d[4], 1'b1)
		wr(3'h3, 8'hBF);
		wr(3'h2, 8'h0B);
		wr(3'h3, 8'h03);
		n = rx_cnt;
		put(8'h13);
		`CHK(tx_pause, 1'b0)
		put(8'h1A);
		`CHK(tx_pause, 1'b1)
		put(8'h11);
		put(8'h22);
		`CHK(tx_pause, 1'b0)
		`CHK(rx_cnt, n)
		{fast, n, rx_level} = {1'b0, flow_cnt, 8'h10};
		tick;
		`CHK(tx_flow_valid, 1'b0)
		tick;
		repeat (4) @(negedge clk_sys);
		`CHK(flow_last, 8'h13)
		rx_level = 8'h09;
		repeat (4) @(negedge clk_sys);
		`CHK(flow_cnt, n + 8'h01)
		rx_level = 8'h08;
		repeat (4) @(negedge clk_sys);
		`CHK(flow_last, 8'h11)
		wr(3'h4, 8'h03);
		repeat (2) @(negedge clk_sys);
		`CHK({rts_n, dtr_n}, 2'h0)
		tx_shift_bit = 1'b0;
		wr(3'h4, 8'h13);
		repeat (2) @(negedge clk_sys);
		`CHK({rts_n, dtr_n, tx_pin, rx_serial}, 4'hE)
		wr(3'h4, 8'h40);
		repeat (4) @(negedge clk_sys);
		`CHK(tx_pin, 1'b0)
		bit_start = 1'b1;
		@(negedge clk_sys);
		bit_start = 1'b0;
		@(negedge clk_sys);
		`CHK(tx_pin, 1'b1)
		repeat (12) @(negedge clk_sys);
		`CHK(tx_pin, 1'b0)
		tx_shift_bit = 1'b1;
		wr(3'h4, 8'h04);
		tx_fifo_empty = 1'b0;
		wr(3'h0, 8'h55);
		repeat (2) @(negedge clk_sys);
		`CHK(half_duplex_direction_n, 1'b0)
		tx_fifo_empty = 1'b1;
		repeat (4) @(negedge clk_sys);
		`CHK(half_duplex_direction_n, 1'b1)
		wr(3'h4, 8'h00);
		wr(3'h1, 8'h10);
		wait_osc(1'b0);
		`CHK(oscillator_output_en, 1'b0)
		ring_indicate_n = 1'b0;
		wait_osc(1'b1);
		`CHK(oscillator_output_en, 1'b1)
		rd(3'h6);
		`CHK(d, 8'h11)
		wait_osc(1'b0);
		`CHK(oscillator_output_en, 1'b0)
		wr(3'h0, 8'h77);
		wait_osc(1'b1);
		`CHK(oscillator_output_en, 1'b1)
		wait_osc(1'b0);
		`CHK(oscillator_output_en, 1'b0)
		core_int = 1'b1;
		wait_osc(1'b1);
		`CHK(oscillator_output_en, 1'b1)
		core_int = 1'b0;
		wr(3'h1, 8'h00);
		repeat (8) @(negedge clk_sys);
		`CHK(oscillator_output_en, 1'b1)
		report_and_stop;
	end
endmodule
`default_nettype wire
